// *** src/byte_port_pkg.sv ***
// package: modes, field widths and reset values for the byte port glue
package byte_port_pkg;
  // host style selection
  typedef enum logic [1:0] {
    HOST_CMD_PAIR = 2'b00, // separate io read and io write commands
    HOST_STROBE = 2'b01, // data strobe with direction and chip select
    HOST_BACKPLANE = 2'b11 // single command strobe plus status bits
  } host_mode_e;
  // byte width of every port
  localparam int BYTE_W = 8;
  typedef logic [BYTE_W-1:0] byte_t;
  // reset values of the stored bytes
  localparam byte_t INPUT_RESET = 8'h00;
  localparam byte_t OUTPUT_RESET = 8'h00;
  // host side control pins, all strobes active low
  typedef struct packed {
    logic ioReadCommandN; // io read command, fast read strobe pin
    logic ioWriteCommandN; // io write command, fast write strobe pin
    logic dataStrobeN; // processor data strobe
    logic readWrite; // high = read
    logic chipSelect; // decoded chip select, high active
    logic readEnableIn; // external decoded read enable
    logic writeEnableIn; // external decoded write enable
    logic statusBitZeroN; // backplane status bit 0, active low
    logic statusBitOneN; // backplane status bit 1, active low
    logic commandN; // backplane command strobe
  } host_ctrl_s;
  // registered state of the block apart from the portOut flops
  typedef struct packed {
    byte_t inputReg; // input register or latch
    byte_t outputLatch; // held output latch value
    logic strobeSeen; // write strobe low in previous cycle
    logic clockSeen; // latch clock high in previous cycle
  } port_state_s;
endpackage : byte_port_pkg

// *** src/mpu_byte_port_glue.sv ***
// byte port glue: host transceiver, input register and output latch
`timescale 1ns/1ns
`default_nettype none
module mpu_byte_port_glue
(
  input wire logic clk, // system clock, 125 MHz
  input wire logic reset, // asynchronous, active high
  input wire byte_port_pkg::host_mode_e hostMode, // host style
  input wire logic fastReadOnly, // strobe host: gate reads by fast strobe
  input wire byte_port_pkg::host_ctrl_s hostCtrl, // host control pins
  input wire byte_port_pkg::byte_t portIn, // host data pins, input side
  output logic [7:0] portOut, // host data pins, output side
  output logic portOe, // high while driving host pins
  input wire byte_port_pkg::byte_t coreData, // core byte for output latch
  input wire logic latchClock, // output latch clock
  input wire logic latchPassEnable, // output latch pass enable
  input wire byte_port_pkg::byte_t secondPortIn, // secondary port pins
  input wire logic secondPortSelect, // read secondary port
  output byte_port_pkg::byte_t inputData, // stored input byte
  output logic ioReadCycle, // decoded read cycle indication
  output logic ioWriteCycle // decoded write cycle indication
);
  import byte_port_pkg::*;

  port_state_s state_q; // registered state
  port_state_s state_d; // next state
  logic readStrobeN; // selected read strobe, active low
  logic writeStrobeN; // selected write strobe, active low
  logic readEnableTerm; // qualified read enable
  logic writeEnableTerm; // qualified write enable
  logic readActive; // transceiver output enable
  logic latchPass; // output latch transparent
  byte_t latchSource; // byte entering the output latch
  byte_t latchView; // output latch value as seen on internal bus

  // backplane status decode: bit one low is read, bit zero low is write
  always_comb
  begin
    ioReadCycle = !hostCtrl.statusBitOneN && hostCtrl.statusBitZeroN;
    ioWriteCycle = !hostCtrl.statusBitZeroN && hostCtrl.statusBitOneN;
  end

  // strobe and enable selection per host style
  always_comb
  begin
    unique case (hostMode)
      HOST_CMD_PAIR:
      begin
        // commands are the fast strobes, enables from external decoder
        readStrobeN = hostCtrl.ioReadCommandN;
        writeStrobeN = hostCtrl.ioWriteCommandN;
        readEnableTerm = hostCtrl.readEnableIn;
        writeEnableTerm = hostCtrl.writeEnableIn;
      end
      HOST_STROBE:
      begin
        writeStrobeN = hostCtrl.dataStrobeN;
        // write enable formed from direction and chip select as given
        writeEnableTerm = hostCtrl.readWrite && hostCtrl.chipSelect;
        if (fastReadOnly)
        begin
          // faster host: fast strobe alone gates reads
          readStrobeN = hostCtrl.ioReadCommandN;
          readEnableTerm = 1'b1;
        end
        else
        begin
          // fast strobe unused, decoded term gates reads
          readStrobeN = 1'b0;
          readEnableTerm = !hostCtrl.dataStrobeN && hostCtrl.readWrite
                           && hostCtrl.chipSelect;
        end
      end
      HOST_BACKPLANE:
      begin
        // command strobe serves both directions
        readStrobeN = hostCtrl.commandN;
        writeStrobeN = hostCtrl.commandN;
        readEnableTerm = ioReadCycle;
        writeEnableTerm = ioWriteCycle;
      end
      default:
      begin
        // illegal mode code: port stays idle
        readStrobeN = 1'b1;
        writeStrobeN = 1'b1;
        readEnableTerm = 1'b0;
        writeEnableTerm = 1'b0;
      end
    endcase
  end

  // output latch source: core byte or secondary port
  assign latchSource = secondPortSelect ? secondPortIn : coreData;
  assign latchPass = latchClock && latchPassEnable;
  assign latchView = latchPass ? latchSource : state_q.outputLatch;

  // transceiver drives only for a qualified read
  assign readActive = !readStrobeN && readEnableTerm;
  assign portOe = readActive;

  // next state
  always_comb
  begin
    state_d = state_q;
    state_d.strobeSeen = !writeStrobeN;
    state_d.clockSeen = latchClock;
    // capture while strobe low, enabled and no read active; host data valid then
    if (!writeStrobeN && writeEnableTerm && !readActive)
    begin
      state_d.inputReg = portIn;
    end
    // transparent while passing; holds from the falling clock onward
    if (latchPass)
    begin
      state_d.outputLatch = latchSource;
    end
  end

  // state register
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_q <= '{inputReg: INPUT_RESET, outputLatch: OUTPUT_RESET,
                   strobeSeen: 1'b0, clockSeen: 1'b0};
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // data outputs from flip-flops
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      portOut <= OUTPUT_RESET;
    end
    else
    begin
      portOut <= latchView;
    end
  end

  assign inputData = state_q.inputReg;

  // write sequence: enabled strobe then stored byte
  sequence wrTake;
    !writeStrobeN && writeEnableTerm && !readActive;
  endsequence

  chk_input_capture: assert property (@(posedge clk) disable iff (reset)
    wrTake |=> inputData == $past(portIn))
    else $error("input byte not captured");
  chk_input_hold: assert property (@(posedge clk) disable iff (reset)
    !writeEnableTerm |=> $stable(inputData))
    else $error("input byte changed without enable");
  chk_oe_qualified: assert property (@(posedge clk) disable iff (reset)
    portOe |-> (hostMode == HOST_CMD_PAIR && !hostCtrl.ioReadCommandN)
      || (hostMode == HOST_STROBE && fastReadOnly && !hostCtrl.ioReadCommandN)
      || (hostMode == HOST_STROBE && !fastReadOnly && !hostCtrl.dataStrobeN
          && hostCtrl.readWrite && hostCtrl.chipSelect)
      || (hostMode == HOST_BACKPLANE && !hostCtrl.commandN && ioReadCycle))
    else $error("port driven outside read");
  chk_strobe_read: assert property (@(posedge clk) disable iff (reset)
    (hostMode == HOST_STROBE && !fastReadOnly && hostCtrl.dataStrobeN) |-> !portOe)
    else $error("read with data strobe high");
  chk_cmd_read: assert property (@(posedge clk) disable iff (reset)
    (hostMode == HOST_CMD_PAIR) |-> portOe == (!hostCtrl.ioReadCommandN
                                              && hostCtrl.readEnableIn))
    else $error("command read gating wrong");
  chk_latch_hold: assert property (@(posedge clk) disable iff (reset)
    !latchPass ##1 !latchPass |-> $stable(state_q.outputLatch))
    else $error("output latch moved while closed");
  chk_latch_pass: assert property (@(posedge clk) disable iff (reset)
    latchPass |=> portOut == $past(latchSource))
    else $error("output latch not transparent");
  chk_status_decode: assert property (@(posedge clk) disable iff (reset)
    !(ioReadCycle && ioWriteCycle)
    && (hostCtrl.statusBitZeroN != hostCtrl.statusBitOneN || !(ioReadCycle || ioWriteCycle)))
    else $error("read and write cycle together");
  chk_back_strobe: assert property (@(posedge clk) disable iff (reset)
    (hostMode == HOST_BACKPLANE && hostCtrl.commandN) |-> !portOe ##1 1'b1)
    else $error("backplane drive without command");
  // previous-cycle flags: strobe release and latch clock fall
  chk_write_release: assert property (@(posedge clk) disable iff (reset)
    state_q.strobeSeen && writeStrobeN |=> $stable(inputData))
    else $error("input byte changed after strobe release");
  chk_latch_fall: assert property (@(posedge clk) disable iff (reset)
    state_q.clockSeen && !latchClock |=> $stable(state_q.outputLatch))
    else $error("output latch moved after clock fall");
  chk_fast_read: assert property (@(posedge clk) disable iff (reset)
    (hostMode == HOST_STROBE && fastReadOnly) |-> portOe == !hostCtrl.ioReadCommandN)
    else $error("fast read gating wrong");
  chk_strobe_write: assert property (@(posedge clk) disable iff (reset)
    (hostMode == HOST_STROBE && !hostCtrl.readWrite) |=> $stable(inputData))
    else $error("strobe write stored without direction high");
endmodule // mpu_byte_port_glue
`default_nettype wire

// *** tb/host_bus_model.sv ***
// host bus model: decoder and command levels for each host style
`timescale 1ns/1ns
`default_nettype none
module host_bus_model
(
  input wire byte_port_pkg::host_mode_e hostMode, // host style
  input wire logic [1:0] op, // 0 idle, 1 read, 2 write
  input wire logic hit, // address matches the port
  input wire byte_port_pkg::byte_t wrData, // write byte
  output byte_port_pkg::host_ctrl_s hostCtrl, // control pins
  output byte_port_pkg::byte_t portIn, // data pins
  output logic [1:0] sizeAck // byte size, no waits
);
  import byte_port_pkg::*;
  logic rd; // read cycle
  logic wr; // write cycle
  logic bp; // backplane style
  assign rd = (op == 2'h1);
  assign wr = (op == 2'h2);
  assign bp = (hostMode == HOST_BACKPLANE);
  // decoder and strobes follow the cycle type
  always_comb
  begin
    hostCtrl.ioReadCommandN = !(rd && !bp);
    hostCtrl.ioWriteCommandN = !(wr && hostMode == HOST_CMD_PAIR);
    hostCtrl.readEnableIn = hit;
    hostCtrl.writeEnableIn = hit;
    hostCtrl.chipSelect = hit;
    hostCtrl.dataStrobeN = !(op != 2'h0 && hostMode == HOST_STROBE);
    hostCtrl.readWrite = rd; // high on reads
    hostCtrl.statusBitOneN = !(rd && bp); // read status
    hostCtrl.statusBitZeroN = !(wr && bp); // write status
    hostCtrl.commandN = !(op != 2'h0 && bp); // single command strobe
  end
  // released lines show the inverse of the write byte
  assign portIn = wr ? wrData : ~wrData;
  assign sizeAck = hit ? 2'h2 : 2'h3;
endmodule // host_bus_model
`default_nettype wire

// *** tb/mpu_byte_port_glue_tb_top.sv ***
// self-checking bench for the byte port glue
`timescale 1ns/1ns
`default_nettype none
module mpu_byte_port_glue_tb_top;
  import byte_port_pkg::*;
  // one table row: inputs, then expected {oe, read cycle, write cycle}
  typedef struct packed {host_mode_e m; logic f; logic [1:0] o; logic h; logic [2:0] e;} row_s;
  row_s rows [11] = '{
    '{HOST_CMD_PAIR, 1'b0, 2'h1, 1'b1, 3'h4}, '{HOST_CMD_PAIR, 1'b0, 2'h1, 1'b0, 3'h0},
    '{HOST_CMD_PAIR, 1'b0, 2'h2, 1'b1, 3'h0}, '{HOST_STROBE, 1'b0, 2'h1, 1'b1, 3'h4},
    '{HOST_STROBE, 1'b0, 2'h1, 1'b0, 3'h0}, '{HOST_STROBE, 1'b1, 2'h1, 1'b0, 3'h4},
    '{HOST_STROBE, 1'b0, 2'h0, 1'b1, 3'h0}, '{HOST_BACKPLANE, 1'b0, 2'h1, 1'b1, 3'h6},
    '{HOST_BACKPLANE, 1'b0, 2'h2, 1'b1, 3'h1}, '{HOST_BACKPLANE, 1'b0, 2'h0, 1'b1, 3'h0},
    '{host_mode_e'(2'b10), 1'b0, 2'h1, 1'b1, 3'h0}};
  logic clk = 1'b0;
  logic reset = 1'b1;
  host_mode_e hostMode = HOST_CMD_PAIR;
  logic fast = 1'b0;
  logic [1:0] op = 2'h0;
  logic hit = 1'b0;
  byte_t wrData = 8'h00;
  byte_t coreData = 8'h00;
  logic latchClock = 1'b0;
  logic latchPassEnable = 1'b1;
  byte_t secondPortIn = 8'h00;
  logic secondPortSelect = 1'b0;
  host_ctrl_s hostCtrl;
  byte_t portIn;
  logic [7:0] portOut;
  logic portOe;
  byte_t inputData;
  logic ioReadCycle;
  logic ioWriteCycle;
  logic [2:0] flags;
  assign flags = {portOe, ioReadCycle, ioWriteCycle};
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  always #4 clk = ~clk;
  host_bus_model u_host_bus_model (.hostMode(hostMode), .op(op), .hit(hit),
    .wrData(wrData), .hostCtrl(hostCtrl), .portIn(portIn), .sizeAck());
  mpu_byte_port_glue u_mpu_byte_port_glue (.clk(clk), .reset(reset), .hostMode(hostMode),
    .fastReadOnly(fast), .hostCtrl(hostCtrl), .portIn(portIn), .portOut(portOut),
    .portOe(portOe), .coreData(coreData), .latchClock(latchClock),
    .latchPassEnable(latchPassEnable),
    .secondPortIn(secondPortIn), .secondPortSelect(secondPortSelect),
    .inputData(inputData), .ioReadCycle(ioReadCycle), .ioWriteCycle(ioWriteCycle));
  // compare flag triples
  task automatic check_flags(input logic [2:0] got, input logic [2:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // compare bytes
  task automatic check_byte(input byte_t got, input byte_t exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // new host cycle at the falling edge
  task automatic drive(input host_mode_e m, input logic f, input logic [1:0] o,
    input logic h, input byte_t d);
    @(negedge clk);
    hostMode = m;
    fast = f;
    op = o;
    hit = h;
    wrData = d;
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 400)
    begin
      errors++;
      tally_and_finish;
    end
  end
  // main sequence
  initial
  begin
    repeat (6) @(negedge clk);
    check_byte(inputData, INPUT_RESET);
    check_byte(portOut, OUTPUT_RESET);
    reset = 1'b0;
    $display("test reset done");
    foreach (rows[i])
    begin
      drive(rows[i].m, rows[i].f, rows[i].o, rows[i].h, 8'h00);
      #1 check_flags(flags, rows[i].e);
    end
    $display("test table done");
    drive(HOST_CMD_PAIR, 1'b0, 2'h2, 1'b1, 8'ha5);
    drive(HOST_CMD_PAIR, 1'b0, 2'h2, 1'b0, 8'h5a);
    check_byte(inputData, 8'ha5);
    drive(HOST_BACKPLANE, 1'b0, 2'h2, 1'b1, 8'h3c);
    check_byte(inputData, 8'ha5);
    drive(HOST_BACKPLANE, 1'b0, 2'h0, 1'b1, 8'h00);
    check_byte(inputData, 8'h3c);
    drive(HOST_STROBE, 1'b0, 2'h2, 1'b1, 8'h69);
    drive(HOST_STROBE, 1'b0, 2'h0, 1'b1, 8'h00);
    check_byte(inputData, 8'h3c);
    $display("test writes done");
    coreData = 8'hc3;
    latchClock = 1'b1;
    repeat (2) @(negedge clk);
    check_byte(portOut, 8'hc3);
    latchClock = 1'b0;
    coreData = 8'h11;
    repeat (2) @(negedge clk);
    check_byte(portOut, 8'hc3);
    latchPassEnable = 1'b0;
    latchClock = 1'b1;
    repeat (2) @(negedge clk);
    check_byte(portOut, 8'hc3);
    latchPassEnable = 1'b1;
    secondPortIn = 8'h7e;
    secondPortSelect = 1'b1;
    latchClock = 1'b1;
    repeat (2) @(negedge clk);
    check_byte(portOut, 8'h7e);
    $display("test latch done");
    reset = 1'b1;
    #1 check_byte(inputData, INPUT_RESET);
    check_byte(portOut, OUTPUT_RESET);
    repeat (2) @(negedge clk);
    reset = 1'b0;
    drive(HOST_CMD_PAIR, 1'b0, 2'h2, 1'b1, 8'h96);
    drive(HOST_CMD_PAIR, 1'b0, 2'h0, 1'b0, 8'h00);
    check_byte(inputData, 8'h96);
    check_byte(portOut, 8'h7e);
    $display("test midrun reset done");
    tally_and_finish;
  end
endmodule // mpu_byte_port_glue_tb_top
`default_nettype wire
